// [verilog/supervisor_pkg.sv]
// Constants, types and state names shared by the signal conflict supervisor.
//
// What this block does
// - Hold 120 pair entries over 16 channels; fitted means conflicting pair.
// - Sixteen amber mask settings; a set mask disables that channel's amber sensing.
// - Missing programming card, seen through its loopback, is a conflict-type failure.
// - Mains loss when line stays below 98 VAC for over 400 ms.
// - During mains loss suspend checks, close fault contact, flash power lamp 2 Hz.
// - Stay in relay-hold mode until mains return is detected.
// - Mains return when line stays above 103 VAC over 400 ms; start recovery.
// - Line below 103 VAC over 400 ms during recovery returns to relay-hold.
// - First 4.0 s of recovery: contact closed, checks suspended, lamp 4 Hz.
// - After that interval, count controller watchdog transitions.
// - Resume monitoring after 5 watchdog transitions or 10 s from mains return.
// - Watchdog never active: watchdog-loss failure and halt output to controller.
// - Red-check permit on applies extended checks to selected channels; off, basic only.
// - One switch per channel selects extended checks, effective only with permit.
// - Coil activation not caused by this device disables extended checks.
// - Keep current and two earlier faults with channel snapshots for review.
// - Current fault shown: card-open lamp 1 Hz, 15 percent duty.
// - Previous fault shown: on 150, off 150, on 150, off 550 ms.
// - Oldest fault shown: three 150 ms pulses then 250 ms off each second.
// - Reset switch held 5 s copies configuration into stored copy.
// - Compare live and stored configuration at reset press and every second; the power-up compare never fires, as stored_valid_q resets to 0.
// - Line below 85 VAC over 400 ms: suspend, de-energize relay, lamp off.
// - Conflict lasting 450 ms fails; 200 ms or less never fails.
`default_nettype none
package supervisor_pkg;
  localparam int CHANNELS = 16;
  localparam int PAIRS = 120;
  localparam int CFG_W = PAIRS + 2 * CHANNELS;
  localparam int PIN_W = 2 + CFG_W + 2 * CHANNELS + 8;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int QUAL_MS = 400;
  localparam int RECOV_HOLD_MS = 4000;
  localparam int RESUME_MS = 10000;
  localparam int WD_EDGES = 5;
  localparam int CONFLICT_FAIL_MS = 450;
  localparam int SAVE_HOLD_MS = 5000;
  localparam int FRAME_MS = 1000;
  localparam int LOSS_HALF_MS = 250;
  localparam int RECOV_HALF_MS = 125;
  localparam int PULSE_MS = 150;
  localparam int GAP_MS = 150;
  localparam int OLDEST_TAIL_MS = 250;
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_CONFLICT = 3'h1;
  localparam logic [2:0] CAUSE_CARD = 3'h2;
  localparam logic [2:0] CAUSE_WDOG = 3'h3;
  localparam logic [2:0] CAUSE_CONFIG = 3'h4;
  localparam logic [1:0] REVIEW_OFF = 2'h0;
  localparam logic [1:0] REVIEW_CUR = 2'h1;
  localparam logic [1:0] REVIEW_PREV = 2'h2;
  localparam logic [1:0] REVIEW_OLDEST = 2'h3;
  typedef enum logic [2:0] {
    PWR_NORMAL,
    PWR_HOLD,
    PWR_RECOV_FLASH,
    PWR_RECOV_WD,
    PWR_BROWN
  } pwr_state_t;
endpackage
`default_nettype wire

// [verilog/signal_conflict_supervisor.sv]
// Supervisory logic of the signal conflict monitor.
`timescale 1ns/1ps
`default_nettype none
module signal_conflict_supervisor #(
  parameter int TICK_CYCLES = supervisor_pkg::TICK_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [supervisor_pkg::CHANNELS-1:0] green_sense,
  input wire logic [supervisor_pkg::CHANNELS-1:0] amber_sense,
  input wire logic [supervisor_pkg::PAIRS-1:0] conflict_fitted,
  input wire logic [supervisor_pkg::CHANNELS-1:0] amber_mask,
  input wire logic [supervisor_pkg::CHANNELS-1:0] extended_sel,
  input wire logic card_loop,
  input wire logic line_below_98,
  input wire logic line_above_103,
  input wire logic line_below_85,
  input wire logic watchdog_in,
  input wire logic red_check_permit,
  input wire logic flash_transfer_coil_input,
  input wire logic reset_switch,
  input wire logic [1:0] review_sel,
  output logic fault_contact_closed_q,
  output logic relay_energized_q,
  output logic halt_q,
  output logic line_power_lamp_q,
  output logic card_open_lamp_q,
  output logic checks_suspended_q,
  output logic failed_q,
  output logic [2:0] fault_cause_q,
  output logic watchdog_loss_fault_q,
  output logic config_change_fault_q,
  output logic [supervisor_pkg::CHANNELS-1:0] extended_active_q,
  output logic [2:0] review_cause_q,
  output logic [supervisor_pkg::CHANNELS-1:0] review_chan_q
);
  import supervisor_pkg::*;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1_q;
  logic [PIN_W-1:0] s2_q;
  logic [PIN_W-1:0] s3_q;
  logic [PIN_W-1:0] pin_q;

  assign pin_raw = {review_sel, extended_sel, amber_mask, conflict_fitted,
                    green_sense, amber_sense, card_loop, line_below_98,
                    line_above_103, line_below_85, watchdog_in,
                    red_check_permit, flash_transfer_coil_input, reset_switch};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A bit moves only when the last two stages agree.
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end

  logic [1:0] p_review;
  logic [CFG_W-1:0] cfg_live;
  logic [PAIRS-1:0] p_fitted;
  logic [CHANNELS-1:0] p_mask;
  logic [CHANNELS-1:0] p_ext;
  logic [CHANNELS-1:0] p_green;
  logic [CHANNELS-1:0] p_amber;
  logic p_card;
  logic p_b98;
  logic p_a103;
  logic p_b85;
  logic p_wd;
  logic p_red;
  logic p_coil;
  logic p_rst_sw;

  assign {p_review, cfg_live, p_green, p_amber, p_card, p_b98, p_a103, p_b85,
          p_wd, p_red, p_coil, p_rst_sw} = pin_q;
  assign {p_ext, p_mask, p_fitted} = cfg_live;

  // ***************************************************************
  // Millisecond tick and one-second phase
  // ***************************************************************
  logic [15:0] div_q;
  logic tick_q;
  logic [9:0] ph_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == 16'(TICK_CYCLES - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h1;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= '0;
    end else if (tick_q) begin
      ph_q <= (ph_q == 10'(FRAME_MS - 1)) ? 10'h0 : ph_q + 10'h1;
    end
  end

  function automatic logic win(input logic [9:0] ph, input int lo, input int len);
    win = (int'(ph) >= lo) && (int'(ph) < lo + len);
  endfunction

  function automatic logic flash_on(input logic [9:0] ph, input int half);
    flash_on = 1'b0;
    for (int n = 0; n < 4; n++) begin
      if (win(ph, n * 2 * half, half)) begin
        flash_on = 1'b1;
      end
    end
  endfunction

  // ***************************************************************
  // Line voltage qualification
  // ***************************************************************
  // Index 0: below 98, 1: above 103, 2: below 103, 3: below 85.
  logic [3:0] cond;
  logic [3:0] qual;
  logic [8:0] qcnt_q [4];

  assign cond = {p_b85, ~p_a103, p_a103, p_b98};

  for (genvar i = 0; i < 4; i++) begin : g_qual
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        qcnt_q[i] <= '0;
      end else if (!cond[i]) begin
        qcnt_q[i] <= '0;
      end else if (tick_q && qcnt_q[i] <= 9'(QUAL_MS)) begin
        qcnt_q[i] <= qcnt_q[i] + 9'h1;
      end
    end
    assign qual[i] = qcnt_q[i] > 9'(QUAL_MS);
  end

  // ***************************************************************
  // Mains loss and recovery
  // ***************************************************************
  pwr_state_t state_q;
  logic [13:0] rec_ms_q;
  logic [2:0] wd_edges_q;
  logic wd_prev_q;
  logic in_recov;
  logic wd_lost;
  logic suspended;

  assign in_recov = (state_q == PWR_RECOV_FLASH) || (state_q == PWR_RECOV_WD);
  assign suspended = state_q != PWR_NORMAL;
  assign wd_lost = (state_q == PWR_RECOV_WD) && !qual[3] && !qual[2] &&
                   rec_ms_q >= 14'(RESUME_MS) && wd_edges_q == 3'h0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PWR_NORMAL;
    end else if (qual[3] && state_q != PWR_BROWN) begin
      state_q <= PWR_BROWN;
    end else begin
      case (state_q)
        PWR_NORMAL: begin
          if (qual[0]) begin
            state_q <= PWR_HOLD;
          end
        end
        PWR_HOLD, PWR_BROWN: begin
          if (qual[1]) begin
            state_q <= PWR_RECOV_FLASH;
          end
        end
        PWR_RECOV_FLASH: begin
          if (qual[2]) begin
            state_q <= PWR_HOLD;
          end else if (rec_ms_q >= 14'(RECOV_HOLD_MS)) begin
            state_q <= PWR_RECOV_WD;
          end
        end
        PWR_RECOV_WD: begin
          if (qual[2]) begin
            state_q <= PWR_HOLD;
          end else if (wd_edges_q >= 3'(WD_EDGES) || rec_ms_q >= 14'(RESUME_MS)) begin
            state_q <= PWR_NORMAL;
          end
        end
        default: state_q <= PWR_NORMAL;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_ms_q <= '0;
    end else if (!in_recov) begin
      rec_ms_q <= '0;
    end else if (tick_q && rec_ms_q < 14'(RESUME_MS)) begin
      rec_ms_q <= rec_ms_q + 14'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_prev_q <= 1'b0;
      wd_edges_q <= '0;
    end else begin
      wd_prev_q <= p_wd;
      if (state_q != PWR_RECOV_WD) begin
        wd_edges_q <= '0;
      end else if (p_wd != wd_prev_q && wd_edges_q < 3'(WD_EDGES)) begin
        wd_edges_q <= wd_edges_q + 3'h1;
      end
    end
  end

  // ***************************************************************
  // Conflict sensing
  // ***************************************************************
  logic [CHANNELS-1:0] active;
  logic conflict_now;
  logic [8:0] cf_ms_q;

  assign active = p_green | (p_amber & ~p_mask);

  always_comb begin
    int k;
    k = 0;
    conflict_now = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      for (int j = i + 1; j < CHANNELS; j++) begin
        if (p_fitted[k] && active[i] && active[j]) begin
          conflict_now = 1'b1;
        end
        k = k + 1;
      end
    end
  end

  // The 450 ms threshold also keeps clear of the 200 ms no-fail limit.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cf_ms_q <= '0;
    end else if (suspended || !conflict_now) begin
      cf_ms_q <= '0;
    end else if (tick_q && cf_ms_q < 9'(CONFLICT_FAIL_MS)) begin
      cf_ms_q <= cf_ms_q + 9'h1;
    end
  end

  // ***************************************************************
  // Configuration store and check
  // ***************************************************************
  logic [CFG_W-1:0] cfg_stored_q;
  logic stored_valid_q;
  logic [12:0] hold_ms_q;
  logic rst_sw_prev_q;
  logic startup_q;
  logic rst_rise;
  logic save_now;
  logic cfg_mismatch;

  assign rst_rise = p_rst_sw && !rst_sw_prev_q;
  assign save_now = tick_q && hold_ms_q == 13'(SAVE_HOLD_MS);
  assign cfg_mismatch = (startup_q || rst_rise || (tick_q && ph_q == 10'h0)) &&
                        stored_valid_q && !suspended && cfg_live != cfg_stored_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ms_q <= '0;
      rst_sw_prev_q <= 1'b0;
      startup_q <= 1'b1;
      stored_valid_q <= 1'b0;
    end else begin
      rst_sw_prev_q <= p_rst_sw;
      startup_q <= 1'b0;
      if (!p_rst_sw) begin
        hold_ms_q <= '0;
      end else if (tick_q && hold_ms_q <= 13'(SAVE_HOLD_MS)) begin
        hold_ms_q <= hold_ms_q + 13'h1;
      end
      if (save_now) begin
        stored_valid_q <= 1'b1;
      end
    end
  end

  // The stored copy stands for nonvolatile memory and is never reset.
  always_ff @(posedge sys_clk) begin
    if (save_now) begin
      cfg_stored_q <= cfg_live;
    end
  end

  // ***************************************************************
  // Fault latch and history
  // ***************************************************************
  logic [2:0] new_cause;
  logic trip;
  logic [2:0] hist_cause_q [3];
  logic [CHANNELS-1:0] hist_chan_q [3];

  always_comb begin
    new_cause = CAUSE_NONE;
    if (wd_lost) begin
      new_cause = CAUSE_WDOG;
    end else if (!suspended && !p_card) begin
      new_cause = CAUSE_CARD;
    end else if (!suspended && cf_ms_q == 9'(CONFLICT_FAIL_MS)) begin
      new_cause = CAUSE_CONFLICT;
    end else if (cfg_mismatch) begin
      new_cause = CAUSE_CONFIG;
    end
  end

  assign trip = !failed_q && new_cause != CAUSE_NONE;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      failed_q <= 1'b0;
      fault_cause_q <= CAUSE_NONE;
      watchdog_loss_fault_q <= 1'b0;
      config_change_fault_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      halt_q <= watchdog_loss_fault_q;
      // While failed_q is clear, a new fault wins over a reset press in the same cycle.
      if (trip) begin
        failed_q <= 1'b1;
        fault_cause_q <= new_cause;
      end else if (rst_rise) begin
        failed_q <= 1'b0;
        fault_cause_q <= CAUSE_NONE;
      end
      if (wd_lost) begin
        watchdog_loss_fault_q <= 1'b1;
      end else if (rst_rise) begin
        watchdog_loss_fault_q <= 1'b0;
      end
      if (cfg_mismatch) begin
        config_change_fault_q <= 1'b1;
      end else if (rst_rise) begin
        config_change_fault_q <= 1'b0;
      end
    end
  end

  // History stands for retained memory, so it carries no reset either.
  always_ff @(posedge sys_clk) begin
    if (trip) begin
      hist_cause_q[2] <= hist_cause_q[1];
      hist_chan_q[2] <= hist_chan_q[1];
      hist_cause_q[1] <= hist_cause_q[0];
      hist_chan_q[1] <= hist_chan_q[0];
      hist_cause_q[0] <= new_cause;
      hist_chan_q[0] <= active;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      review_cause_q <= CAUSE_NONE;
      review_chan_q <= '0;
    end else if (p_review == REVIEW_OFF) begin
      review_cause_q <= CAUSE_NONE;
      review_chan_q <= '0;
    end else begin
      review_cause_q <= hist_cause_q[p_review - 2'h1];
      review_chan_q <= hist_chan_q[p_review - 2'h1];
    end
  end

  // ***************************************************************
  // Outputs: relay, extended checks, lamps
  // ***************************************************************
  logic coil_uncaused;

  assign coil_uncaused = p_coil && !fault_contact_closed_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_contact_closed_q <= 1'b0;
      relay_energized_q <= 1'b0;
      checks_suspended_q <= 1'b0;
      extended_active_q <= '0;
    end else begin
      // Reset clears both; from the first clock on, the contact closes when the relay drops, so the two stay opposite.
      fault_contact_closed_q <= suspended || failed_q;
      relay_energized_q <= !(suspended || failed_q);
      checks_suspended_q <= suspended;
      if (p_red && !coil_uncaused && !suspended) begin
        extended_active_q <= p_ext;
      end else begin
        extended_active_q <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_power_lamp_q <= 1'b0;
    end else begin
      case (state_q)
        PWR_HOLD: line_power_lamp_q <= flash_on(ph_q, LOSS_HALF_MS);
        PWR_RECOV_FLASH: line_power_lamp_q <= flash_on(ph_q, RECOV_HALF_MS);
        PWR_BROWN: line_power_lamp_q <= 1'b0;
        default: line_power_lamp_q <= 1'b1;
      endcase
    end
  end

  // The oldest pattern shows its fifth slot lit, giving three pulses.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_open_lamp_q <= 1'b0;
    end else if (!p_card) begin
      card_open_lamp_q <= 1'b1;
    end else begin
      case (p_review)
        REVIEW_CUR: card_open_lamp_q <= win(ph_q, 0, PULSE_MS);
        REVIEW_PREV: card_open_lamp_q <= win(ph_q, 0, PULSE_MS) ||
                                         win(ph_q, PULSE_MS + GAP_MS, PULSE_MS);
        REVIEW_OLDEST: card_open_lamp_q <= win(ph_q, 0, PULSE_MS) ||
            win(ph_q, PULSE_MS + GAP_MS, PULSE_MS) ||
            win(ph_q, FRAME_MS - OLDEST_TAIL_MS - PULSE_MS, PULSE_MS);
        default: card_open_lamp_q <= 1'b0;
      endcase
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_hold_closed;
    state_q == PWR_HOLD ##1 fault_contact_closed_q;
  endsequence

  sequence s_wd_fault_halt;
    watchdog_loss_fault_q ##1 halt_q;
  endsequence

  AST_CONFLICT_TRIP: assert property (
    !failed_q && !suspended && p_card && !wd_lost &&
    cf_ms_q == 9'(CONFLICT_FAIL_MS) |=> failed_q && fault_cause_q == CAUSE_CONFLICT)
    else $error("conflict did not latch a failure");
  AST_CARD_FAIL: assert property (
    !failed_q && !suspended && !p_card && !wd_lost |=> failed_q && fault_cause_q == CAUSE_CARD)
    else $error("missing card did not latch a failure");
  AST_HOLD_ENTRY: assert property (
    state_q == PWR_NORMAL && qual[0] && !qual[3] |=> s_hold_closed)
    else $error("mains loss did not hold the contact closed");
  AST_HOLD_STAYS: assert property (
    state_q == PWR_HOLD && !qual[1] && !qual[3] |=> state_q == PWR_HOLD)
    else $error("relay hold left without mains return");
  AST_RECOV_DROP: assert property (
    in_recov && qual[2] && !qual[3] |=> state_q == PWR_HOLD)
    else $error("recovery ignored a line drop");
  AST_RESUME: assert property (
    state_q == PWR_RECOV_WD && !qual[2] && !qual[3] && wd_edges_q == 3'(WD_EDGES)
    |=> state_q == PWR_NORMAL ##1 !fault_contact_closed_q || failed_q)
    else $error("watchdog transitions did not resume monitoring");
  AST_WD_LOSS: assert property (
    wd_lost |=> s_wd_fault_halt)
    else $error("watchdog loss did not raise halt");
  AST_BROWN: assert property (
    state_q == PWR_BROWN |=> !relay_energized_q && !line_power_lamp_q)
    else $error("brown-out left relay or lamp on");
  AST_EXT_GATE: assert property (
    !p_red || coil_uncaused |=> extended_active_q == '0)
    else $error("extended checks active without permit");
  AST_CFG_SAVE: assert property (
    save_now |=> stored_valid_q && cfg_stored_q == $past(cfg_live))
    else $error("configuration was not stored");
endmodule
`default_nettype wire

// [tb/controller_model.sv]
// Behavioural signal controller that toggles its watchdog output on request.
`timescale 1ns/1ps
`default_nettype none
module controller_model #(
  parameter int HALF = 40
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic halt,
  output var logic watchdog_in
);
  int cnt;
  // ****
  // Watchdog toggling
  // ****
  // A halted controller stops its program, so its watchdog freezes like a real one.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      watchdog_in <= 1'b0;
    end else if (run && !halt) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        watchdog_in <= ~watchdog_in;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_signal_conflict_supervisor.sv]
// Self-checking bench for the signal conflict supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb_signal_conflict_supervisor;
  import supervisor_pkg::*;
  localparam int TK = 3;
  localparam int LIMIT = 100000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [CHANNELS-1:0] green_sense = 16'h0000;
  logic [CHANNELS-1:0] amber_sense = 16'h0000;
  logic [PAIRS-1:0] conflict_fitted = 120'h0;
  logic [CHANNELS-1:0] amber_mask = 16'h0000;
  logic [CHANNELS-1:0] extended_sel = 16'h0000;
  logic card_loop = 1'b1;
  logic line_below_98 = 1'b0;
  logic line_above_103 = 1'b1;
  logic line_below_85 = 1'b0;
  logic watchdog_in;
  logic red_check_permit = 1'b0;
  logic flash_transfer_coil_input = 1'b0;
  logic reset_switch = 1'b0;
  logic [1:0] review_sel = 2'h0;
  logic wd_run = 1'b0;
  logic fault_contact_closed_q, relay_energized_q, halt_q, line_power_lamp_q;
  logic card_open_lamp_q, checks_suspended_q, failed_q, watchdog_loss_fault_q;
  logic config_change_fault_q;
  logic [2:0] fault_cause_q, review_cause_q;
  logic [CHANNELS-1:0] extended_active_q, review_chan_q;
  int err_count = 0;
  int check_count = 0;
  int cyc_n = 0;

  signal_conflict_supervisor #(.TICK_CYCLES(TK)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .green_sense(green_sense), .amber_sense(amber_sense), .conflict_fitted(conflict_fitted),
    .amber_mask(amber_mask), .extended_sel(extended_sel), .card_loop(card_loop),
    .line_below_98(line_below_98), .line_above_103(line_above_103),
    .line_below_85(line_below_85), .watchdog_in(watchdog_in),
    .red_check_permit(red_check_permit), .flash_transfer_coil_input(flash_transfer_coil_input),
    .reset_switch(reset_switch), .review_sel(review_sel),
    .fault_contact_closed_q(fault_contact_closed_q), .relay_energized_q(relay_energized_q),
    .halt_q(halt_q), .line_power_lamp_q(line_power_lamp_q),
    .card_open_lamp_q(card_open_lamp_q), .checks_suspended_q(checks_suspended_q),
    .failed_q(failed_q), .fault_cause_q(fault_cause_q),
    .watchdog_loss_fault_q(watchdog_loss_fault_q),
    .config_change_fault_q(config_change_fault_q), .extended_active_q(extended_active_q),
    .review_cause_q(review_cause_q), .review_chan_q(review_chan_q));

  controller_model #(.HALF(40)) u_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .run(wd_run),
    .halt(halt_q), .watchdog_in(watchdog_in));

  always #12.5 sys_clk = ~sys_clk;

  // ****
  // Helpers
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Checks sample at the falling edge so the rising-edge updates have landed.
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic ms(input int n);
    cyc(n * TK);
  endtask

  task automatic press(input int hold_ms);
    @(posedge sys_clk);
    reset_switch <= 1'b1;
    ms(hold_ms);
    @(posedge sys_clk);
    reset_switch <= 1'b0;
    cyc(12);
  endtask

  // Exactly 200 enabled edges give five watchdog changes.
  task automatic wd_burst;
    @(posedge sys_clk);
    wd_run <= 1'b1;
    repeat (200) @(posedge sys_clk);
    wd_run <= 1'b0;
    cyc(1);
  endtask

  // One full lamp frame; the patterns repeat each frame, so counts are exact.
  task automatic lamps(output int nl, output int nc);
    nl = 0;
    nc = 0;
    repeat (FRAME_MS * TK) begin
      @(negedge sys_clk);
      nl += line_power_lamp_q;
      nc += card_open_lamp_q;
    end
  endtask

  task end_sim;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == LIMIT) begin
      err_count++;
      end_sim;
    end
  end

  // ****
  // Scenarios
  // ****
  initial begin : main
    int nl;
    int nc;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(10);
    press(2);
    chk(failed_q, 1'b0);
    chk(relay_energized_q, 1'b1);
    @(posedge sys_clk);
    card_loop <= 1'b0;
    cyc(10);
    chk(fault_cause_q, CAUSE_CARD);
    @(posedge sys_clk);
    card_loop <= 1'b1;
    press(2);
    @(posedge sys_clk);
    conflict_fitted <= 120'h1;
    green_sense <= 16'h0003;
    ms(200);
    @(posedge sys_clk);
    green_sense <= 16'h0006;
    amber_sense <= 16'h0001;
    amber_mask <= 16'h0001;
    ms(500);
    chk(failed_q, 1'b0);
    @(posedge sys_clk);
    green_sense <= 16'h0003;
    ms(460);
    chk(fault_cause_q, CAUSE_CONFLICT);
    @(posedge sys_clk);
    green_sense <= 16'h0000;
    amber_sense <= 16'h0000;
    amber_mask <= 16'h0000;
    press(2);
    for (int k = 1; k < 4; k++) begin
      @(posedge sys_clk);
      review_sel <= 2'(k);
      cyc(10);
      if (k == 1) begin
        chk(review_chan_q, 16'h0003);
      end
      chk(review_cause_q, (k == 1) ? CAUSE_CONFLICT : CAUSE_CARD);
      lamps(nl, nc);
      chk(nc, k * PULSE_MS * TK);
    end
    @(posedge sys_clk);
    review_sel <= REVIEW_OFF;
    red_check_permit <= 1'b1;
    extended_sel <= 16'h00f0;
    cyc(10);
    chk(extended_active_q, 16'h00f0);
    @(posedge sys_clk);
    flash_transfer_coil_input <= 1'b1;
    cyc(10);
    chk(extended_active_q, 16'h0000);
    @(posedge sys_clk);
    flash_transfer_coil_input <= 1'b0;
    red_check_permit <= 1'b0;
    cyc(10);
    chk(extended_active_q, 16'h0000);
    press(SAVE_HOLD_MS + 10);
    chk(config_change_fault_q, 1'b0);
    @(posedge sys_clk);
    amber_mask <= 16'h0020;
    ms(1100);
    chk(fault_cause_q, CAUSE_CONFIG);
    chk(config_change_fault_q, 1'b1);
    @(posedge sys_clk);
    amber_mask <= 16'h0000;
    press(2);
    chk(failed_q, 1'b0);
    @(posedge sys_clk);
    line_above_103 <= 1'b0;
    line_below_98 <= 1'b1;
    ms(405);
    chk(checks_suspended_q, 1'b1);
    lamps(nl, nc);
    chk(nl, LOSS_HALF_MS * 2 * TK);
    chk(fault_contact_closed_q, 1'b1);
    @(posedge sys_clk);
    line_below_98 <= 1'b0;
    line_above_103 <= 1'b1;
    ms(405);
    wd_burst();
    lamps(nl, nc);
    chk(nl, RECOV_HALF_MS * 4 * TK);
    ms(2960);
    chk(fault_contact_closed_q, 1'b1);
    wd_burst();
    cyc(20);
    chk(fault_contact_closed_q, 1'b0);
    @(posedge sys_clk);
    line_above_103 <= 1'b0;
    line_below_98 <= 1'b1;
    ms(405);
    @(posedge sys_clk);
    line_below_98 <= 1'b0;
    line_above_103 <= 1'b1;
    ms(405);
    @(posedge sys_clk);
    line_above_103 <= 1'b0;
    ms(405);
    // Both flash rates light half the frame, so count rising edges instead.
    nc = 0;
    repeat (FRAME_MS * TK) begin
      nl = line_power_lamp_q;
      @(negedge sys_clk);
      nc += (line_power_lamp_q && !nl);
    end
    chk(nc, FRAME_MS / (LOSS_HALF_MS * 2));
    @(posedge sys_clk);
    line_above_103 <= 1'b1;
    ms(10410);
    chk(halt_q, 1'b1);
    chk(fault_cause_q, CAUSE_WDOG);
    chk(watchdog_loss_fault_q, 1'b1);
    // Clear the latched failure so the relay is energized before the brown-out.
    press(2);
    chk(relay_energized_q, 1'b1);
    @(posedge sys_clk);
    line_above_103 <= 1'b0;
    line_below_98 <= 1'b1;
    line_below_85 <= 1'b1;
    ms(405);
    chk(relay_energized_q, 1'b0);
    chk(line_power_lamp_q, 1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
